// ===== hw/codec_serial_cfg.svh
// constants for the codec serial mode and frame sync block
// Operation
// - version field in bits 29-32 or 17-20
// - modes three/four: each sync rise starts frame
// - modes one/two: sync high two bit clocks
// - longer sync high accepted beyond minimum
// - no per-word sync pulses needed, modes one/two
// - format select 00..11 gives modes one..four, except 11 with pin three low gives mode three
// - master select honoured only in modes three/four
// - master drives bit clock and frame sync
// - frame length from two length selects, modes three/four
// - mode three slave 11: bit clock is master clock
// - pin three low keeps legacy modes
`ifndef CODEC_SERIAL_CFG_SVH
`define CODEC_SERIAL_CFG_SVH

// version reported in the outgoing frame (4 bits)
`define CSM_VERSION 4'h1
// first and last frame bit of the version, 1-based from frame start
`define CSM_VER_FIRST_SDO 9'd29
`define CSM_VER_LAST_SDO 9'd32
`define CSM_VER_FIRST_CDO 9'd17
`define CSM_VER_LAST_CDO 9'd20
// sample word occupies frame bits 1..16
`define CSM_SAMPLE_LAST 9'd16
// frame lengths in bits
`define CSM_BPF_32 9'd32
`define CSM_BPF_64 9'd64
`define CSM_BPF_128 9'd128
`define CSM_BPF_256 9'd256
// sync high bit clocks needed in modes one and two
`define CSM_SYNC_MIN_LEGACY 2'd2
// core clock period and master bit clock half period
`define CSM_CLK_NS 100
`define CSM_BCLK_HALF_NS 400
`define CSM_BCLK_HALF_CYC ((`CSM_BCLK_HALF_NS + `CSM_CLK_NS - 1) / `CSM_CLK_NS)
// cycles of agreement before the configuration is captured
`define CSM_CFG_SETTLE 2'd3
// fifo shape
`define CSM_FIFO_DEPTH 4
`define CSM_SAMPLE_W 16

`endif

// ===== hw/codec_serial_pkg.sv
// types for the codec serial mode and frame sync block
package codec_serial_pkg;

	// serial port modes
	typedef enum logic [1:0] {
		serial_mode_one,
		serial_mode_two,
		serial_mode_three,
		serial_mode_four
	} serial_mode_e;

	// captured static configuration
	typedef struct packed {
		serial_mode_e mode;
		logic master;
		logic bclk_is_mclk;
		logic [8:0] frame_bits;
	} port_cfg_s;

	// raw selection pins
	typedef struct packed {
		logic port_format_sel_hi;
		logic port_format_sel_lo;
		logic serial_mode_pin_three;
		logic master_select;
		logic frame_length_sel_hi;
		logic frame_length_sel_lo;
	} sel_pins_s;

endpackage

// ===== hw/codec_serial_mode_frame_sync.sv
// serial mode selection, frame sync detection and frame output with sample fifo
`timescale 1ns/10ps
`include "codec_serial_cfg.svh"

// small flip-flop fifo, registered ready
module sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// full mark sized one bit wider than the index so the depth itself fits
	localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_ptr; // write index
	logic [AW-1:0] rd_ptr; // read index
	logic [AW:0] count; // words held
	logic push; // accepted write
	logic pop; // accepted read
	logic [AW:0] next_count; // count after this cycle

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// count update
	always_comb begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + 1'b1;
		end else if (pop & ~push) begin
			next_count = count - 1'b1;
		end
	end

	// pointers, count and registered ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
		end else begin
			count <= next_count;
			in_ready <= (next_count < DEPTH_C);
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	// one storage entry per word
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_entry
			always_ff @(posedge clk) begin
				if (push && wr_ptr == AW'(gi)) begin
					mem[gi] <= in_data;
				end
			end
		end
	endgenerate
endmodule

// top: mode decode, bit clock, frame sync and frame shifter
module codec_serial_mode_frame_sync (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PORT_FORMAT_SEL_HI,
	input wire logic PORT_FORMAT_SEL_LO,
	input wire logic SERIAL_MODE_PIN_THREE,
	input wire logic MASTER_SELECT,
	input wire logic FRAME_LENGTH_SEL_HI,
	input wire logic FRAME_LENGTH_SEL_LO,
	input wire logic BIT_CLOCK_IN,
	output logic BIT_CLOCK_OUT,
	output logic BIT_CLOCK_OE,
	input wire logic FRAME_SYNC_IN,
	output logic FRAME_SYNC_OUT,
	output logic FRAME_SYNC_OE,
	input wire logic SAMPLE_VALID,
	output logic SAMPLE_READY,
	input wire logic [`CSM_SAMPLE_W-1:0] SAMPLE_DATA,
	output logic SERIAL_DATA_OUT,
	output logic CONTROL_DATA_OUT,
	output logic FRAME_START,
	output logic CFG_VALID,
	output logic [1:0] MODE,
	output logic IS_MASTER,
	output logic BCLK_IS_MCLK,
	output logic [8:0] FRAME_BITS
);
	codec_serial_pkg::sel_pins_s pins_raw; // raw selection pins
	codec_serial_pkg::sel_pins_s pins_s1; // synchroniser stage one
	codec_serial_pkg::sel_pins_s pins_s2; // synchroniser stage two
	codec_serial_pkg::sel_pins_s pins_s3; // synchroniser stage three
	logic [1:0] settle; // agreement counter
	codec_serial_pkg::port_cfg_s cfg; // captured configuration
	codec_serial_pkg::port_cfg_s next_cfg; // decoded configuration
	logic cfg_valid; // configuration captured

	logic bclk_s1, bclk_s2, bclk_s3; // bit clock synchroniser
	logic bclk_lvl; // agreed bit clock level
	logic fs_s1, fs_s2, fs_s3; // frame sync synchroniser
	logic fs_lvl; // agreed frame sync level
	logic fs_prev; // frame sync at previous bit tick
	logic [1:0] fs_high; // bit ticks sync has been high
	logic [2:0] div; // master bit clock divider
	logic bclk_gen; // generated bit clock
	logic bit_tick; // one pulse per rising bit clock
	logic in_frame; // inside a frame
	logic [8:0] bit_num; // 1-based bit of the frame
	logic start_now; // frame begins at this tick
	logic [`CSM_SAMPLE_W-1:0] sample; // word being sent
	logic fifo_valid; // fifo holds a word
	logic [`CSM_SAMPLE_W-1:0] fifo_data; // fifo head word
	logic fifo_pop; // take a word at frame start
	logic [8:0] out_num; // bit number presented this tick
	logic [3:0] ver; // version field
	logic ver_sdo; // version bit slot on serial data out
	logic ver_cdo; // version bit slot on control data out
	logic [8:0] sdo_idx; // version index, serial data out
	logic [8:0] cdo_idx; // version index, control data out

	assign pins_raw = '{PORT_FORMAT_SEL_HI, PORT_FORMAT_SEL_LO, SERIAL_MODE_PIN_THREE,
		MASTER_SELECT, FRAME_LENGTH_SEL_HI, FRAME_LENGTH_SEL_LO};
	assign ver = `CSM_VERSION;

	// decode selection pins into a configuration
	always_comb begin
		next_cfg = '0;
		// format select picks the mode; pin three low keeps legacy modes
		unique case ({pins_s3.port_format_sel_hi, pins_s3.port_format_sel_lo})
			2'b00: next_cfg.mode = codec_serial_pkg::serial_mode_one;
			2'b01: next_cfg.mode = codec_serial_pkg::serial_mode_two;
			2'b10: next_cfg.mode = codec_serial_pkg::serial_mode_three;
			2'b11: next_cfg.mode = pins_s3.serial_mode_pin_three ?
				codec_serial_pkg::serial_mode_four : codec_serial_pkg::serial_mode_three;
		endcase
		// modes one and two are always slave
		next_cfg.master = pins_s3.master_select &
			(next_cfg.mode == codec_serial_pkg::serial_mode_three ||
			next_cfg.mode == codec_serial_pkg::serial_mode_four);
		// frame length table
		unique case (next_cfg.mode)
			codec_serial_pkg::serial_mode_one, codec_serial_pkg::serial_mode_two: begin
				next_cfg.frame_bits = `CSM_BPF_256;
			end
			codec_serial_pkg::serial_mode_three: begin
				if (!pins_s3.frame_length_sel_hi) begin
					next_cfg.frame_bits = pins_s3.frame_length_sel_lo ? `CSM_BPF_128 : `CSM_BPF_64;
				end else begin
					next_cfg.frame_bits = next_cfg.master ? `CSM_BPF_128 : `CSM_BPF_256;
				end
			end
			codec_serial_pkg::serial_mode_four: begin
				if (!pins_s3.frame_length_sel_hi) begin
					next_cfg.frame_bits = pins_s3.frame_length_sel_lo ? `CSM_BPF_64 : `CSM_BPF_32;
				end else begin
					next_cfg.frame_bits = next_cfg.master ? `CSM_BPF_64 : `CSM_BPF_128;
				end
			end
		endcase
		// bit clock doubles as master clock
		next_cfg.bclk_is_mclk = (next_cfg.mode == codec_serial_pkg::serial_mode_three) &
			~next_cfg.master & pins_s3.frame_length_sel_hi & pins_s3.frame_length_sel_lo;
	end

	// selection pin synchroniser and one-time capture
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pins_s1 <= '0;
			pins_s2 <= '0;
			pins_s3 <= '0;
			settle <= 2'd0;
			cfg <= '0;
			cfg_valid <= 1'b0;
		end else begin
			pins_s1 <= pins_raw;
			pins_s2 <= pins_s1;
			pins_s3 <= pins_s2;
			if (pins_s2 != pins_s3) begin
				settle <= 2'd0;
			end else if (settle != `CSM_CFG_SETTLE) begin
				settle <= settle + 2'd1;
			end
			// captured once; later pin changes wait for the next reset
			if (!cfg_valid && settle == `CSM_CFG_SETTLE && pins_s2 == pins_s3) begin
				cfg <= next_cfg;
				cfg_valid <= 1'b1;
			end
		end
	end

	// link pin synchronisers, level taken when stages two and three agree
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bclk_s1 <= 1'b0;
			bclk_s2 <= 1'b0;
			bclk_s3 <= 1'b0;
			bclk_lvl <= 1'b0;
			fs_s1 <= 1'b0;
			fs_s2 <= 1'b0;
			fs_s3 <= 1'b0;
			fs_lvl <= 1'b0;
		end else begin
			bclk_s1 <= BIT_CLOCK_IN;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			fs_s1 <= FRAME_SYNC_IN;
			fs_s2 <= fs_s1;
			fs_s3 <= fs_s2;
			if (bclk_s2 == bclk_s3) begin
				bclk_lvl <= bclk_s3;
			end
			if (fs_s2 == fs_s3) begin
				fs_lvl <= fs_s3;
			end
		end
	end

	// master bit clock divider and bit tick
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			div <= 3'd0;
			bclk_gen <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= 1'b0;
			if (cfg_valid && cfg.master) begin
				// generate the bit clock ourselves
				if (div == 3'(`CSM_BCLK_HALF_CYC - 1)) begin
					div <= 3'd0;
					bclk_gen <= ~bclk_gen;
					bit_tick <= ~bclk_gen;
				end else begin
					div <= div + 3'd1;
				end
			end else if (cfg_valid) begin
				// slave: rising edge of the far end's bit clock
				bclk_gen <= bclk_lvl;
				bit_tick <= bclk_lvl & ~bclk_gen;
			end
		end
	end

	// frame start decision at each bit tick
	always_comb begin
		start_now = 1'b0;
		if (cfg.master) begin
			// own frames run back to back
			start_now = ~in_frame | (bit_num == cfg.frame_bits);
		end else if (cfg.mode == codec_serial_pkg::serial_mode_three ||
			cfg.mode == codec_serial_pkg::serial_mode_four) begin
			// any rising sync starts a frame, its length ignored
			start_now = fs_lvl & ~fs_prev;
		end else begin
			// second tick of sync high starts a frame, longer high ignored
			start_now = fs_lvl & (fs_high == `CSM_SYNC_MIN_LEGACY - 2'd1);
		end
	end

	// sync history, frame position and sample hand-off
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fs_prev <= 1'b0;
			fs_high <= 2'd0;
			in_frame <= 1'b0;
			bit_num <= 9'd0;
			sample <= '0;
		end else if (bit_tick) begin
			fs_prev <= fs_lvl;
			if (!fs_lvl) begin
				fs_high <= 2'd0;
			end else if (fs_high != 2'd3) begin
				fs_high <= fs_high + 2'd1;
			end
			if (start_now) begin
				in_frame <= 1'b1;
				bit_num <= 9'd1;
				sample <= fifo_valid ? fifo_data : '0;
			end else if (in_frame && bit_num == cfg.frame_bits) begin
				// frame ends; words need no sync of their own
				in_frame <= 1'b0;
			end else if (in_frame) begin
				bit_num <= bit_num + 9'd1;
			end
		end
	end

	assign fifo_pop = bit_tick & start_now;
	assign out_num = (bit_tick & start_now) ? 9'd1 : bit_num + 9'd1;
	assign ver_sdo = (out_num >= `CSM_VER_FIRST_SDO) && (out_num <= `CSM_VER_LAST_SDO);
	assign ver_cdo = (out_num >= `CSM_VER_FIRST_CDO) && (out_num <= `CSM_VER_LAST_CDO);
	assign sdo_idx = `CSM_VER_LAST_SDO - out_num;
	assign cdo_idx = `CSM_VER_LAST_CDO - out_num;

	// serial and control data out, msb first
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			SERIAL_DATA_OUT <= 1'b0;
			CONTROL_DATA_OUT <= 1'b0;
		end else if (bit_tick) begin
			if (!(start_now || (in_frame && bit_num != cfg.frame_bits))) begin
				SERIAL_DATA_OUT <= 1'b0;
				CONTROL_DATA_OUT <= 1'b0;
			end else begin
				if (out_num <= `CSM_SAMPLE_LAST) begin
					SERIAL_DATA_OUT <= start_now ? (fifo_valid & fifo_data[`CSM_SAMPLE_W-1]) :
						sample[4'(`CSM_SAMPLE_LAST - out_num)];
				end else if (ver_sdo && cfg.mode != codec_serial_pkg::serial_mode_four) begin
					SERIAL_DATA_OUT <= ver[2'(sdo_idx)];
				end else begin
					SERIAL_DATA_OUT <= 1'b0;
				end
				if (ver_cdo && cfg.mode == codec_serial_pkg::serial_mode_four) begin
					CONTROL_DATA_OUT <= ver[2'(cdo_idx)];
				end else begin
					CONTROL_DATA_OUT <= 1'b0;
				end
			end
		end
	end

	// pin drive and status outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BIT_CLOCK_OUT <= 1'b0;
			BIT_CLOCK_OE <= 1'b0;
			FRAME_SYNC_OUT <= 1'b0;
			FRAME_SYNC_OE <= 1'b0;
			FRAME_START <= 1'b0;
			CFG_VALID <= 1'b0;
			MODE <= 2'd0;
			IS_MASTER <= 1'b0;
			BCLK_IS_MCLK <= 1'b0;
			FRAME_BITS <= 9'd0;
		end else begin
			// master drives both link pins, slave leaves them
			BIT_CLOCK_OE <= cfg_valid & cfg.master;
			FRAME_SYNC_OE <= cfg_valid & cfg.master;
			BIT_CLOCK_OUT <= cfg_valid & cfg.master & bclk_gen;
			if (bit_tick && cfg.master) begin
				FRAME_SYNC_OUT <= start_now; // one bit clock high per frame
			end else if (!cfg.master) begin
				FRAME_SYNC_OUT <= 1'b0;
			end
			FRAME_START <= fifo_pop;
			CFG_VALID <= cfg_valid;
			MODE <= cfg.mode;
			IS_MASTER <= cfg.master;
			BCLK_IS_MCLK <= cfg.bclk_is_mclk;
			FRAME_BITS <= cfg.frame_bits;
		end
	end

	sample_fifo #(
		.WIDTH(`CSM_SAMPLE_W),
		.DEPTH(`CSM_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.in_valid(SAMPLE_VALID),
		.in_ready(SAMPLE_READY),
		.in_data(SAMPLE_DATA),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);
endmodule

// ===== test/codec_frame_chk.sv
// concurrent checks on the ports of the codec serial mode block
`timescale 1ns/10ps
module codec_frame_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PORT_FORMAT_SEL_HI,
	input wire logic PORT_FORMAT_SEL_LO,
	input wire logic SERIAL_MODE_PIN_THREE,
	input wire logic MASTER_SELECT,
	input wire logic BIT_CLOCK_OE,
	input wire logic FRAME_SYNC_OUT,
	input wire logic FRAME_SYNC_OE,
	input wire logic FRAME_START,
	input wire logic CFG_VALID,
	input wire logic [1:0] MODE,
	input wire logic IS_MASTER,
	input wire logic BCLK_IS_MCLK,
	input wire logic [8:0] FRAME_BITS
);
	logic [11:0] gap; // cycles since the last frame start
	logic seen; // a frame start was seen since reset
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// frame spacing counter
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gap <= 12'h000;
			seen <= 1'b0;
		end else begin
			gap <= FRAME_START ? 12'h001 : gap + 12'h001;
			seen <= seen | FRAME_START;
		end
	end
	// master sync: one bit period high, then low
	sequence s_sync_bit;
		FRAME_SYNC_OUT [*8] ##1 !FRAME_SYNC_OUT;
	endsequence
	property p_sync_len;
		$rose(FRAME_SYNC_OUT) |-> s_sync_bit;
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync pulse length wrong");
	property p_sync_follows;
		FRAME_START && IS_MASTER |-> ##[0:2] FRAME_SYNC_OUT;
	endproperty
	a_sync_follows: assert property (p_sync_follows) else $error("no sync out");
	property p_master_oe;
		CFG_VALID |-> BIT_CLOCK_OE == IS_MASTER && FRAME_SYNC_OE == IS_MASTER;
	endproperty
	a_master_oe: assert property (p_master_oe) else $error("drive enable wrong");
	property p_decode;
		$rose(CFG_VALID) |-> MODE == {PORT_FORMAT_SEL_HI,
			PORT_FORMAT_SEL_LO & (~PORT_FORMAT_SEL_HI | SERIAL_MODE_PIN_THREE)};
	endproperty
	a_decode: assert property (p_decode) else $error("mode decode wrong");
	property p_master_sel;
		$rose(CFG_VALID) |-> IS_MASTER == (MODE[1] & MASTER_SELECT);
	endproperty
	a_master_sel: assert property (p_master_sel) else $error("master select wrong");
	property p_legacy_bits;
		CFG_VALID && !MODE[1] |-> FRAME_BITS == 9'h100 && !BCLK_IS_MCLK;
	endproperty
	a_legacy_bits: assert property (p_legacy_bits) else $error("legacy length wrong");
	property p_cfg_hold;
		CFG_VALID && $past(CFG_VALID) |-> $stable({MODE, IS_MASTER, FRAME_BITS});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
	property p_period;
		FRAME_START && seen && IS_MASTER |-> gap == {FRAME_BITS, 3'h0};
	endproperty
	a_period: assert property (p_period) else $error("master frame period wrong");
	property p_pulse;
		FRAME_START |=> !FRAME_START;
	endproperty
	a_pulse: assert property (p_pulse) else $error("frame start too long");
endmodule

bind codec_serial_mode_frame_sync codec_frame_chk i_codec_frame_chk (.CLK(CLK), .RST_N(RST_N),
	.PORT_FORMAT_SEL_HI(PORT_FORMAT_SEL_HI), .PORT_FORMAT_SEL_LO(PORT_FORMAT_SEL_LO),
	.SERIAL_MODE_PIN_THREE(SERIAL_MODE_PIN_THREE), .MASTER_SELECT(MASTER_SELECT),
	.BIT_CLOCK_OE(BIT_CLOCK_OE), .FRAME_SYNC_OUT(FRAME_SYNC_OUT),
	.FRAME_SYNC_OE(FRAME_SYNC_OE), .FRAME_START(FRAME_START), .CFG_VALID(CFG_VALID),
	.MODE(MODE), .IS_MASTER(IS_MASTER), .BCLK_IS_MCLK(BCLK_IS_MCLK), .FRAME_BITS(FRAME_BITS));

// ===== test/far_end_port.sv
// far end serial port model: bit clock and frame sync for slave sub-modes
`timescale 1ns/10ps
module far_end_port (
	output logic bclk,
	output logic fsync
);
	// both still low outside frames, edges on the core clock grid
	initial begin
		bclk = 1'b0;
		fsync = 1'b0;
	end
	// nb bit clocks, sync high for the first hi, set up half a bit early
	task automatic frame(input int hi, input int nb);
		for (int i = 0; i < nb; i++) begin
			fsync = (i < hi);
			#400 bclk = 1'b1;
			#400 bclk = 1'b0;
		end
		fsync = 1'b0;
	endtask
endmodule

// ===== test/tb_top.sv
// self-checking testbench for the codec serial mode block
`timescale 1ns/10ps
`include "codec_serial_cfg.svh"
module tb_top;
	logic clk = 1'b0; // core clock
	logic rst_n = 1'b0; // reset, active low
	codec_serial_pkg::sel_pins_s pins = '0; // selection pins
	logic sv = 1'b0; // sample valid
	logic [15:0] sd = 16'h0000; // sample data
	logic bo, bo_oe, fo, fo_oe, fb, ff; // clock and sync of both ends
	logic sdo, cdo, fst, cfgv, ism, bim, srdy; // design outputs
	logic [1:0] mode; // decoded mode
	logic [8:0] fbits; // frame length
	logic [31:0] got; // collected frame bits
	logic [31:0] gotc; // collected control data bits
	int n_fail = 0; // mismatches
	int compares = 0; // comparisons
	int cyc = 0; // cycle count
	int starts = 0; // frame starts seen
	int t0; // cycle of a frame start
	// pins beside expected {mode, master, bclk flag, bits}
	logic [18:0] rows [13] = '{19'h00100, 19'h2c900, 19'h41040, 19'h4b480, 19'h4f480,
		19'h47300, 19'h61040, 19'h75880, 19'h7bc40, 19'h79c20, 19'h73840, 19'h45100, 19'h08100};
	// core clock, 100 ns
	always #50 clk = ~clk;
	// cycle and frame start counters, watchdog
	always @(posedge clk) begin
		cyc++;
		if (fst === 1'b1) starts++;
		if (cyc == 6000) begin
			n_fail++;
			stop_test();
		end
	end
	codec_serial_mode_frame_sync i_codec_serial_mode_frame_sync (.CLK(clk), .RST_N(rst_n),
		.PORT_FORMAT_SEL_HI(pins.port_format_sel_hi), .PORT_FORMAT_SEL_LO(pins.port_format_sel_lo),
		.SERIAL_MODE_PIN_THREE(pins.serial_mode_pin_three), .MASTER_SELECT(pins.master_select),
		.FRAME_LENGTH_SEL_HI(pins.frame_length_sel_hi),
		.FRAME_LENGTH_SEL_LO(pins.frame_length_sel_lo),
		.BIT_CLOCK_IN(bo_oe ? bo : fb), .BIT_CLOCK_OUT(bo), .BIT_CLOCK_OE(bo_oe),
		.FRAME_SYNC_IN(fo_oe ? fo : ff), .FRAME_SYNC_OUT(fo), .FRAME_SYNC_OE(fo_oe),
		.SAMPLE_VALID(sv), .SAMPLE_READY(srdy), .SAMPLE_DATA(sd), .SERIAL_DATA_OUT(sdo),
		.CONTROL_DATA_OUT(cdo), .FRAME_START(fst), .CFG_VALID(cfgv), .MODE(mode),
		.IS_MASTER(ism), .BCLK_IS_MCLK(bim), .FRAME_BITS(fbits));
	far_end_port i_far_end_port (.bclk(fb), .fsync(ff));
	// compare and count
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %0t got %0h want %0h", $time, g, e);
		end
	endtask
	// verdict and end of run
	task automatic stop_test;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// new pins, short reset, wait for capture
	task automatic reset_to(input logic [18:0] r);
		@(negedge clk);
		pins = r[18:13];
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
	endtask
	// push one word, held until ready
	task automatic push(input logic [15:0] d);
		@(negedge clk);
		sv = 1'b1;
		sd = d;
		while (srdy !== 1'b1) @(negedge clk);
		@(negedge clk);
		sv = 1'b0;
	endtask
	// run a far end frame and keep 32 bits from bit clock rise first on
	task automatic grab(input int hi, input int nb, input int first);
		fork
			i_far_end_port.frame(hi, nb);
			repeat (first + 31) begin
				@(posedge fb);
				got = {got[30:0], sdo};
				gotc = {gotc[30:0], cdo};
			end
		join
	endtask
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		check(srdy, 1'b0); // no pushes during reset
		rst_n = 1'b1;
		foreach (rows[i]) begin
			reset_to(rows[i]);
			check({cfgv, mode, ism, bim, fbits}, {1'b1, rows[i][12:0]});
			check(bo_oe, rows[i][10]);
		end
		// mode three slave, fill fifo until refused
		reset_to(19'h41040);
		push(16'ha1b2);
		push(16'hc3d4);
		push(16'he5f6);
		push(16'h0789);
		@(negedge clk);
		sv = 1'b1;
		repeat (2) @(negedge clk);
		check(srdy, 1'b0); // fifo full
		sv = 1'b0;
		starts = 0;
		grab(1, 40, 2);
		check(got, {16'ha1b2, 12'h000, `CSM_VERSION});
		grab(3, 40, 2);
		check(got, {16'hc3d4, 12'h000, `CSM_VERSION});
		check(starts, 2);
		@(negedge clk);
		pins = '0;
		repeat (10) @(negedge clk);
		check(mode, 2'h2);
		// mode one: short sync refused, long sync accepted once
		reset_to(19'h00100);
		starts = 0;
		i_far_end_port.frame(1, 6);
		check(starts, 0);
		grab(5, 40, 3);
		check(got, {28'h0000000, `CSM_VERSION});
		check(starts, 1);
		// mode four slave: version on control data out, serial data silent
		reset_to(19'h75880);
		grab(1, 40, 2);
		check(gotc, {16'h0000, `CSM_VERSION, 12'h000});
		check(got, 32'h00000000);
		// mode four master, 32 bit frames
		reset_to(19'h79c20);
		check(bo_oe & fo_oe, 1'b1);
		starts = 0;
		wait (starts == 1);
		t0 = cyc;
		wait (starts == 2);
		check(cyc - t0, 32 * 8);
		// generated bit clock period, eight core cycles
		@(posedge bo);
		@(negedge clk);
		t0 = cyc;
		@(posedge bo);
		@(negedge clk);
		check(cyc - t0, 8);
		stop_test();
	end
endmodule
